// File: design/enable_sync_device.sv
`timescale 1ns/100ps
// Functional notes
// - Below wake level: full shutdown, nothing active
// - Between thresholds: internal supply on, no switching
// - Above enable threshold with supply: switch normally
// - Ignore level changes during blank after edge
// - No blanking while in shutdown
// - Far end holds low beyond maximum blank
// - Sync detector triggers on rising edge
// - Far end sync clock within frequency range
// - Sync phases longer than edge, shorter blank
// - Far end keeps sync off until started
// - After 2048 valid cycles, jump to sync
// - Valid sync disables spread spectrum, follows clock
// - Resistor setting spans internal frequency range
// - Fold frequency back on on/off time limits
// - Duty limit 87 normal, 98 in foldback
// - Far end holds each sync level at least 100 ns
// - Nudge phase until sync and switch align
// - First pulse after turn-on delay
module enable_sync_device
#(
    parameter int TURN_ON_CYC = enable_sync_pkg::TURN_ON_CYC_DEF,
    parameter int LOCK_COUNT = enable_sync_pkg::SYNC_LOCK_CYCLES
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Combined enable and sync input
    enable_sync_if.dev LINK,
    // Operating conditions
    input wire logic VIN_OK,
    input wire logic [enable_sync_pkg::PER_W-1:0] FREQ_SET_RESISTOR_PIN,
    input wire logic [enable_sync_pkg::DUTY_W-1:0] DUTY_REQ,
    // Status and drive
    output logic VCC_ON,
    output logic SWITCHING,
    output logic SWITCH_NODE,
    output logic SYNC_LOCKED,
    output logic SPREAD_EN,
    output logic FOLDBACK
);
    import enable_sync_pkg::*;

    localparam int DLY_W = $clog2(TURN_ON_CYC + 1);

    typedef enum {ST_SHUTDOWN, ST_STANDBY, ST_DELAY, ST_RUN} power_e;

    power_e state;
    power_e next_state;
    logic wake_s1, wake_s2, lvl_s1, lvl_s2, lvl_d, vin_s1, vin_s2;
    logic [PER_W-1:0] res_s1, res_s2;
    logic [PER_W-1:0] age, next_age, cyc, next_cyc;
    logic en_acc, next_en_acc, hi_ok, next_hi_ok;
    logic [DLY_W-1:0] dly, next_dly;
    logic [SYNC_CNT_W-1:0] sync_cnt, next_sync_cnt;
    logic locked, next_locked;
    logic [PER_W-1:0] sync_per, per_eff, next_per_eff, osc, next_osc;
    logic edge_seen, rise, fall, settled, phase_ok, run, reset_sync;
    logic lock_now, wrap, viol, fold_active, phase_fix, enabled;
    logic [PER_W-1:0] res_per, per_target, req_on, on_cyc, ph_step, adj;
    logic [DUTY_W-1:0] duty_in, duty_lim, duty_use;
    logic [PROD_W-1:0] req_prod, on_prod;

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            lvl_s1 <= 1'b0;
            lvl_s2 <= 1'b0;
            lvl_d <= 1'b0;
            vin_s1 <= 1'b0;
            vin_s2 <= 1'b0;
            res_s1 <= PER_MAX;
            res_s2 <= PER_MAX;
        end
        else
        begin
            wake_s1 <= LINK.wake_level;
            wake_s2 <= wake_s1;
            lvl_s1 <= LINK.enable_level;
            lvl_s2 <= lvl_s1;
            lvl_d <= lvl_s2;
            vin_s1 <= VIN_OK;
            vin_s2 <= vin_s1;
            res_s1 <= FREQ_SET_RESISTOR_PIN;
            res_s2 <= res_s1;
        end
    end

    // Edge detection and age since last edge
    assign edge_seen = lvl_s2 != lvl_d;
    assign rise = lvl_s2 && !lvl_d;
    assign fall = !lvl_s2 && lvl_d;
    assign settled = (age == BLANK_CYC) && !edge_seen;
    assign next_age = edge_seen ? '0 : (age == BLANK_CYC) ? age : age + 1'b1;
    assign next_cyc = rise ? 12'h001 : (cyc == PER_FOLD_MAX) ? cyc : cyc + 1'b1;

    // Accepted enable level: blanked unless coming out of shutdown
    assign next_en_acc = !wake_s2 ? 1'b0 :
        (state == ST_SHUTDOWN) ? lvl_s2 :
        settled ? lvl_s2 : en_acc;
    assign enabled = en_acc && vin_s2;
    assign run = state == ST_RUN;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_SHUTDOWN:
                if (wake_s2)
                    next_state = ST_STANDBY;
            ST_STANDBY:
                if (!wake_s2)
                    next_state = ST_SHUTDOWN;
                else if (enabled)
                    next_state = ST_DELAY;
            ST_DELAY:
                if (!wake_s2)
                    next_state = ST_SHUTDOWN;
                else if (!enabled)
                    next_state = ST_STANDBY;
                else if (dly == DLY_W'(TURN_ON_CYC - 1))
                    next_state = ST_RUN;
            ST_RUN:
                if (!wake_s2)
                    next_state = ST_SHUTDOWN;
                else if (!enabled)
                    next_state = ST_STANDBY;
            default:
                next_state = ST_SHUTDOWN;
        endcase
    end

    assign next_dly = (state == ST_DELAY) ? dly + 1'b1 : '0;

    // Sync qualification: each phase between edge time and blank time
    assign phase_ok = (age >= EDGE_CYC - 1'b1) &&
        (age < BLANK_CYC - 1'b1);
    assign next_hi_ok = fall ? phase_ok : hi_ok;
    assign reset_sync = !run || settled || (edge_seen && !phase_ok) ||
        (rise && !hi_ok);
    assign lock_now = !reset_sync && rise && !locked &&
        (sync_cnt == SYNC_CNT_W'(LOCK_COUNT - 1));
    assign next_sync_cnt = reset_sync ? '0 :
        (rise && !locked) ? sync_cnt + 1'b1 : sync_cnt;
    assign next_locked = reset_sync ? 1'b0 : (lock_now || locked);

    // Internal period from resistor, clamped to legal range
    assign res_per = (res_s2 < PER_MIN) ? PER_MIN :
        (res_s2 > PER_MAX) ? PER_MAX : res_s2;
    assign per_target = locked ? sync_per : res_per;

    // Foldback: lengthen period while on or off time is too short
    assign duty_in = (DUTY_REQ > DUTY_FULL) ? DUTY_FULL : DUTY_REQ;
    assign req_prod = per_eff * duty_in;
    assign req_on = PER_W'(req_prod / PROD_W'(DUTY_FULL));
    assign viol = ((duty_in != '0) && (req_on < TON_MIN_CYC)) ||
        ((per_eff - req_on) < TOFF_MIN_CYC);
    assign fold_active = per_eff > per_target;
    assign wrap = osc >= per_eff - 1'b1;
    assign next_per_eff = lock_now ? cyc :
        !wrap ? per_eff :
        (viol && (per_eff <= PER_FOLD_MAX - FOLD_STEP)) ?
            per_eff + FOLD_STEP :
        (per_eff <= per_target) ? per_target :
        (per_eff - per_target > FOLD_STEP) ? per_eff - FOLD_STEP :
            per_target;

    // Duty clamp and on time
    assign duty_lim = fold_active ? DUTY_MAX_FOLD : DUTY_MAX_NORM;
    assign duty_use = (duty_in > duty_lim) ? duty_lim : duty_in;
    assign on_prod = per_eff * duty_use;
    assign on_cyc = PER_W'(on_prod / PROD_W'(DUTY_FULL));

    // Phase pull toward rising sync edge, a fraction of a period per edge
    assign ph_step = (per_eff >> PHASE_SHIFT) + 1'b1;
    assign phase_fix = locked && rise && (osc != '0);
    assign adj = (osc < (per_eff >> 1)) ?
        ((osc > ph_step) ? osc - ph_step : '0) :
        ((per_eff - 1'b1 - osc > ph_step) ? osc + ph_step :
            per_eff - 1'b1);
    assign next_osc = !run ? '0 : phase_fix ? adj :
        wrap ? '0 : osc + 1'b1;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state <= ST_SHUTDOWN;
            age <= '0;
            cyc <= '0;
            en_acc <= 1'b0;
            hi_ok <= 1'b0;
            dly <= '0;
            sync_cnt <= '0;
            locked <= 1'b0;
            sync_per <= PER_MAX;
            per_eff <= PER_MAX;
            osc <= '0;
        end
        else
        begin
            state <= next_state;
            age <= next_age;
            cyc <= next_cyc;
            en_acc <= next_en_acc;
            hi_ok <= next_hi_ok;
            dly <= next_dly;
            sync_cnt <= next_sync_cnt;
            locked <= next_locked;
            sync_per <= rise ? cyc : sync_per;
            per_eff <= next_per_eff;
            osc <= next_osc;
        end
    end

    // Registered outputs
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            VCC_ON <= 1'b0;
            SWITCHING <= 1'b0;
            SWITCH_NODE <= 1'b0;
            SYNC_LOCKED <= 1'b0;
            SPREAD_EN <= 1'b0;
            FOLDBACK <= 1'b0;
        end
        else
        begin
            VCC_ON <= next_state != ST_SHUTDOWN;
            SWITCHING <= next_state == ST_RUN;
            SWITCH_NODE <= run && (osc < on_cyc);
            SYNC_LOCKED <= next_locked;
            SPREAD_EN <= run && !next_locked;
            FOLDBACK <= run && fold_active;
        end
    end

endmodule : enable_sync_device

// File: include/enable_sync_pkg.sv
package enable_sync_pkg;

    // Clock rate and printed times
    localparam int CLK_MHZ = 250;
    localparam int T_BLANK_MIN_NS = 4000;
    localparam int T_BLANK_MAX_NS = 28000;
    localparam int T_SYNC_EDGE_NS = 100;
    localparam int T_TURN_ON_US = 700;
    localparam int T_TON_MIN_NS = 70;
    localparam int T_TOFF_MIN_NS = 85;
    localparam int F_MIN_KHZ = 200;
    localparam int F_MAX_KHZ = 2200;
    localparam int NS_PER_US = 1000;
    localparam int KHZ_PER_MHZ = 1000;

    // Widths
    localparam int PER_W = 12;
    localparam int DUTY_W = 7;
    localparam int SYNC_CNT_W = 12;
    localparam int PROD_W = PER_W + DUTY_W;

    // Counts and limits
    localparam int SYNC_LOCK_CYCLES = 2048;
    localparam int TURN_ON_CYC_DEF = T_TURN_ON_US * CLK_MHZ;
    localparam int DISABLE_CYC_DEF = T_BLANK_MAX_NS * CLK_MHZ / NS_PER_US + 1;
    localparam logic [PER_W-1:0] BLANK_CYC =
        PER_W'((T_BLANK_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [PER_W-1:0] EDGE_CYC =
        PER_W'((T_SYNC_EDGE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [PER_W-1:0] TON_MIN_CYC =
        PER_W'((T_TON_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [PER_W-1:0] TOFF_MIN_CYC =
        PER_W'((T_TOFF_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [PER_W-1:0] PER_MIN =
        PER_W'((CLK_MHZ * KHZ_PER_MHZ + F_MAX_KHZ - 1) / F_MAX_KHZ);
    localparam logic [PER_W-1:0] PER_MAX =
        PER_W'(CLK_MHZ * KHZ_PER_MHZ / F_MIN_KHZ);
    localparam logic [PER_W-1:0] PER_FOLD_MAX = {PER_W{1'b1}};
    localparam logic [PER_W-1:0] FOLD_STEP = 12'h004;
    localparam int PHASE_SHIFT = 5;
    localparam logic [PER_W-1:0] HALF_MIN = (PER_MIN + 12'h001) >> 1;
    localparam logic [PER_W-1:0] HALF_MAX = PER_MAX >> 1;

    // Duty cycle limits in percent
    localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64;
    localparam logic [DUTY_W-1:0] DUTY_MAX_NORM = 7'h57;
    localparam logic [DUTY_W-1:0] DUTY_MAX_FOLD = 7'h62;

endpackage : enable_sync_pkg

// File: include/enable_sync_if.sv
`timescale 1ns/100ps
interface enable_sync_if;
    // Comparator outputs of the combined enable and sync input
    logic wake_level;
    logic enable_level;
    modport dev (input wake_level, input enable_level);
    modport host (output wake_level, output enable_level);
endinterface : enable_sync_if

// File: design/enable_sync_host.sv
`timescale 1ns/100ps
module enable_sync_host
#(
    parameter int DISABLE_CYC = enable_sync_pkg::DISABLE_CYC_DEF
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Combined enable and sync input of the regulator
    enable_sync_if.host LINK,
    // Requests
    input wire logic WAKE_REQ,
    input wire logic ENABLE_REQ,
    input wire logic STARTUP_DONE,
    input wire logic SYNC_REQ,
    input wire logic [enable_sync_pkg::PER_W-1:0] SYNC_HALF,
    // Status
    output logic SYNC_ACTIVE,
    output logic DISABLE_HOLD
);
    import enable_sync_pkg::*;

    localparam int HOLD_W = $clog2(DISABLE_CYC + 1);

    logic en_on, next_en_on, phase, next_phase, holding, sync_on, half_end;
    logic [HOLD_W-1:0] hold, next_hold;
    logic [PER_W-1:0] half, div, next_div;

    // Low hold after a disable outlasts the longest blank
    assign holding = hold != '0;
    assign next_en_on = ENABLE_REQ && (en_on || !holding);
    assign next_hold = (en_on && !ENABLE_REQ) ? HOLD_W'(DISABLE_CYC) :
        holding ? hold - 1'b1 : '0;

    // Sync half period kept inside frequency and phase limits
    assign half = (SYNC_HALF < HALF_MIN) ? HALF_MIN :
        (SYNC_HALF > HALF_MAX) ? HALF_MAX : SYNC_HALF;
    assign sync_on = en_on && ENABLE_REQ && SYNC_REQ && STARTUP_DONE;
    assign half_end = div >= half - 1'b1;
    assign next_div = (!sync_on || half_end) ? '0 : div + 1'b1;
    assign next_phase = !sync_on ? 1'b1 : half_end ? !phase : phase;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            en_on <= 1'b0;
            hold <= '0;
            div <= '0;
            phase <= 1'b1;
            LINK.wake_level <= 1'b0;
            LINK.enable_level <= 1'b0;
            SYNC_ACTIVE <= 1'b0;
            DISABLE_HOLD <= 1'b0;
        end
        else
        begin
            en_on <= next_en_on;
            hold <= next_hold;
            div <= next_div;
            phase <= next_phase;
            LINK.wake_level <= WAKE_REQ || next_en_on;
            LINK.enable_level <= next_en_on && next_phase;
            SYNC_ACTIVE <= sync_on;
            DISABLE_HOLD <= next_hold != '0;
        end
    end

endmodule : enable_sync_host

// File: verif/enable_sync_control_monitor.sv
`timescale 1ns/100ps
module enable_sync_control_monitor
#(
    parameter int TURN_ON_CYC = 50
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Link levels
    input wire logic wake_level,
    input wire logic enable_level,
    // Device inputs and status
    input wire logic VIN_OK,
    input wire logic VCC_ON,
    input wire logic SWITCHING,
    input wire logic SWITCH_NODE,
    input wire logic SYNC_LOCKED,
    input wire logic SPREAD_EN,
    input wire logic FOLDBACK
);
    logic [11:0] run;
    logic en_q;
    wire changed = enable_level != en_q;
    wire [11:0] next_run = changed ? 12'h000 : run + {11'h000, run != 12'hfff};

    // Cycles since the enable level last moved, saturating
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            run <= 12'h000;
            en_q <= 1'b0;
        end
        else
        begin
            run <= next_run;
            en_q <= enable_level;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    a_shutdown_quiet: assert property (!wake_level [*8] |->
        !VCC_ON && !SWITCHING && !SWITCH_NODE) else $error("active in shutdown");
    a_wake_supply: assert property ($rose(wake_level) |-> ##[1:8] VCC_ON)
        else $error("supply did not wake");
    a_idle_node: assert property (!SWITCHING [*2] |-> !SWITCH_NODE)
        else $error("switch node active while idle");
    a_start_delay: assert property ($rose(SWITCHING) |->
        enable_level && run >= TURN_ON_CYC) else $error("switching too early");
    a_blank_hold: assert property ($fell(SWITCHING) && VIN_OK && wake_level
        |-> !enable_level && run >= 12'h3de) else $error("disable inside blank");
    a_lock_in_run: assert property ($rose(SYNC_LOCKED) |-> SWITCHING)
        else $error("lock outside run");
    a_spread_off: assert property (SYNC_LOCKED [*2] |-> !SPREAD_EN)
        else $error("spread spectrum with lock");
    a_lock_timeout: assert property (run >= 12'h3f2 |-> !SYNC_LOCKED)
        else $error("lock held without edges");

    c_lock: cover property ($rose(SYNC_LOCKED));
    c_disable: cover property ($fell(SWITCHING) && VCC_ON);
    c_fold: cover property ($rose(FOLDBACK));
    c_shutdown: cover property ($fell(VCC_ON));
endmodule : enable_sync_control_monitor

// File: verif/enable_sync_control_tb.sv
`timescale 1ns/100ps
module enable_sync_control_tb;
    import enable_sync_pkg::*;
    localparam int TON = 50;
    logic clk, nrst, wake_req, enable_req, startup_done, sync_req, vin_ok;
    logic [11:0] sync_half, freq_set;
    logic [6:0] duty_req;
    logic vcc_on, switching, switch_node, sync_locked, spread_en, foldback;
    logic sync_active, disable_hold;
    logic [31:0] seed = 32'h0000_0031;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int per_q[$];

    enable_sync_if link();
    enable_sync_device #(.TURN_ON_CYC(TON), .LOCK_COUNT(8)) enable_sync_device_i (
        .CLK(clk), .NRST(nrst), .LINK(link), .VIN_OK(vin_ok),
        .FREQ_SET_RESISTOR_PIN(freq_set), .DUTY_REQ(duty_req),
        .VCC_ON(vcc_on), .SWITCHING(switching), .SWITCH_NODE(switch_node),
        .SYNC_LOCKED(sync_locked), .SPREAD_EN(spread_en), .FOLDBACK(foldback));
    enable_sync_host #(.DISABLE_CYC(1100)) enable_sync_host_i (
        .CLK(clk), .NRST(nrst), .LINK(link), .WAKE_REQ(wake_req),
        .ENABLE_REQ(enable_req), .STARTUP_DONE(startup_done),
        .SYNC_REQ(sync_req), .SYNC_HALF(sync_half),
        .SYNC_ACTIVE(sync_active), .DISABLE_HOLD(disable_hold));
    enable_sync_control_monitor #(.TURN_ON_CYC(TON)) monitor_i (
        .CLK(clk), .NRST(nrst), .wake_level(link.wake_level),
        .enable_level(link.enable_level), .VIN_OK(vin_ok), .VCC_ON(vcc_on),
        .SWITCHING(switching), .SWITCH_NODE(switch_node),
        .SYNC_LOCKED(sync_locked), .SPREAD_EN(spread_en), .FOLDBACK(foldback));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic wait_on(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
    endtask : wait_on

    // High and low run lengths of one switching period
    task automatic measure(output int hi, output int lo);
        int n;
        hi = 0;
        lo = 0;
        wait_on(switch_node, 1'b0, n);
        wait_on(switch_node, 1'b1, n);
        while (switch_node === 1'b1 && hi < 5000)
        begin
            hi++;
            @(negedge clk);
        end
        while (switch_node === 1'b0 && lo < 5000)
        begin
            lo++;
            @(negedge clk);
        end
    endtask : measure

    task final_report();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            n_fail++;
            final_report();
        end
    end

    initial
    begin
        int n, hi, lo, h, f, d;
        {nrst, wake_req, enable_req, startup_done, sync_req} = 5'h00;
        vin_ok = 1'b1;
        sync_half = 12'h064;
        freq_set = 12'h4e2;
        duty_req = 7'h32;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        check(16'({vcc_on, switching}), 16'h0000);
        @(posedge clk);
        wake_req <= 1'b1;
        tick(20);
        check(16'({vcc_on, switching, switch_node}), 16'h0004);
        // Out of standby the enable edge is only taken once it has settled
        @(posedge clk);
        enable_req <= 1'b1;
        wait_on(switching, 1'b1, n);
        check(16'(n >= BLANK_CYC + TON && n <= BLANK_CYC + TON + 12),
            16'h0001);
        @(posedge clk);
        vin_ok <= 1'b0;
        tick(10);
        check(16'(switching), 16'h0000);
        @(posedge clk);
        vin_ok <= 1'b1;
        wait_on(switching, 1'b1, n);
        check(16'(n <= TON + 12), 16'h0001);
        f = 1250;
        for (int i = 0; i < 3; i++)
        begin
            f = f - 1 - int'(rnd() % 20);
            d = (i == 2) ? 95 : 20 + int'(rnd() % 60);
            per_q.push_back(f);
            @(posedge clk);
            freq_set <= 12'(f);
            duty_req <= 7'(d);
            tick(10000);
            measure(hi, lo);
            check(16'(hi + lo), 16'(per_q.pop_front()));
            check(16'(hi), 16'(f * ((d > 87) ? 87 : d) / 100));
        end
        @(posedge clk);
        duty_req <= 7'h01;
        wait_on(foldback, 1'b1, n);
        check(16'(n < 2600), 16'h0001);
        @(posedge clk);
        duty_req <= 7'h32;
        wait_on(foldback, 1'b0, n);
        check(16'(n < 2600), 16'h0001);
        h = 57 + int'(rnd() % 144);
        @(posedge clk);
        sync_half <= 12'(h);
        sync_req <= 1'b1;
        tick(20);
        check(16'({sync_active, spread_en}), 16'h0001);
        // A short burst must not leave a partial count behind
        @(posedge clk);
        startup_done <= 1'b1;
        tick(10 * h);
        @(posedge clk);
        startup_done <= 1'b0;
        tick(1200);
        check(16'(sync_locked), 16'h0000);
        @(posedge clk);
        startup_done <= 1'b1;
        wait_on(sync_locked, 1'b1, n);
        check(16'(n >= 18 * h - 2 && n <= 18 * h + 12), 16'h0001);
        tick(48 * h);
        check(16'(spread_en), 16'h0000);
        // Once aligned, the switch pulse follows the next rising sync edge closely
        wait_on(link.enable_level, 1'b0, n);
        wait_on(link.enable_level, 1'b1, n);
        wait_on(switch_node, 1'b1, n);
        check(16'(n >= 3 && n <= 6), 16'h0001);
        measure(hi, lo);
        check(16'(hi + lo), 16'(2 * h));
        check(16'(hi), 16'(h));
        @(posedge clk);
        startup_done <= 1'b0;
        wait_on(sync_locked, 1'b0, n);
        check(16'(n <= 1010), 16'h0001);
        tick(3000);
        measure(hi, lo);
        check(16'(hi + lo), 16'(f));
        @(posedge clk);
        enable_req <= 1'b0;
        tick(900);
        check(16'(switching), 16'h0001);
        tick(150);
        check(16'({switching, disable_hold}), 16'h0001);
        tick(100);
        check(16'(disable_hold), 16'h0000);
        @(posedge clk);
        wake_req <= 1'b0;
        tick(10);
        check(16'({vcc_on, switching, switch_node}), 16'h0000);
        @(posedge clk);
        wake_req <= 1'b1;
        enable_req <= 1'b1;
        wait_on(switching, 1'b1, n);
        check(16'(n >= TON && n <= TON + 12), 16'h0001);
        final_report();
    end
endmodule : enable_sync_control_tb
